/* File: logic/elr_event_link_router.sv */
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// RULE1 - Event inputs bypass interrupt controller entirely
// RULE2 - Hardware forwards every event, no CPU
// RULE3 - Twenty-six selectors, each bound to one source
// RULE4 - Selectors 0-7: edges, key return, RTC
// RULE5 - Selectors 8-12: timer-D matches and underflow
// RULE6 - Selectors 13-25: timer-J0, arrays, comparator
// RULE7 - Each code picks one destination only
// RULE8 - Code decode table, zero means disabled
// RULE9 - Pulses start ADC, update DAC, count J0
// RULE10 - Array channels 0-3 receive routed event
// RULE11 - Timer-D unit0 gets capture and cutoff
// RULE12 - Timer-D unit1 gets capture and cutoff
// RULE13 - PWM unit gets forced cutoff request
// RULE14 - ADC and J0 paths have zero latency
// RULE15 - DAC trigger within two cycles
// RULE16 - PWM cutoff within two cycles
// RULE17 - Software writes only defined destination codes
// RULE18 - Disabled routes nothing; one pulse otherwise
module elr_event_link_router (
   input  wire logic                     CORE_CLK_I,
   input  wire logic                     RESET_N_I,
   // Classic Wishbone slave
   input  wire logic                     WB_CYC_I,
   input  wire logic                     WB_STB_I,
   input  wire logic                     WB_WE_I,
   input  wire logic [elr_pkg::ADR_W-1:0] WB_ADR_I,
   input  wire logic [3:0]               WB_SEL_I,
   input  wire logic [elr_pkg::DAT_W-1:0] WB_DAT_I,
   output logic      [elr_pkg::DAT_W-1:0] WB_DAT_O,
   output logic                          WB_ACK_O,
   // Event sources, one-cycle pulses from on-chip logic
   input  wire logic                     EXT_EDGE_EVENT0_I,
   input  wire logic                     EXT_EDGE_EVENT1_I,
   input  wire logic                     EXT_EDGE_EVENT2_I,
   input  wire logic                     EXT_EDGE_EVENT3_I,
   input  wire logic                     EXT_EDGE_EVENT4_I,
   input  wire logic                     EXT_EDGE_EVENT5_I,
   input  wire logic                     KEY_RETURN_EVENT_I,
   input  wire logic                     RTC_TICK_EVENT_I,
   input  wire logic                     TMD0_MATCH_A_EVENT_I,
   input  wire logic                     TMD0_MATCH_B_EVENT_I,
   input  wire logic                     TMD1_MATCH_A_EVENT_I,
   input  wire logic                     TMD1_MATCH_B_EVENT_I,
   input  wire logic                     TMD1_UNDERFLOW_EVENT_I,
   input  wire logic                     TMJ0_EVENT_I,
   input  wire logic                     TARR0_CH0_EVENT_I,
   input  wire logic                     TARR0_CH1_EVENT_I,
   input  wire logic                     TARR0_CH2_EVENT_I,
   input  wire logic                     TARR0_CH3_EVENT_I,
   input  wire logic                     TARR0_CH4_EVENT_I,
   input  wire logic                     COMPARATOR0_EVENT_I,
   input  wire logic                     TARR0_CH5_EVENT_I,
   input  wire logic                     TARR0_CH6_EVENT_I,
   input  wire logic                     TARR0_CH7_EVENT_I,
   input  wire logic                     TARR1_CH0_EVENT_I,
   input  wire logic                     TARR1_CH1_EVENT_I,
   input  wire logic                     TARR1_CH2_EVENT_I,
   // Destination triggers
   output logic                          ADC_START_O,
   output logic                          DAC_UPDATE_O,
   output logic                          TARR0_CH0_TRIG_O,
   output logic                          TARR0_CH1_TRIG_O,
   output logic                          TARR0_CH2_TRIG_O,
   output logic                          TARR0_CH3_TRIG_O,
   output logic                          TMJ0_COUNT_O,
   output logic                          TMD0_CAPTURE_O,
   output logic                          TMD0_CUTOFF_O,
   output logic                          TMD1_CAPTURE_O,
   output logic                          TMD1_CUTOFF_O,
   output logic                          PWM_CUTOFF_O
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   elr_pkg::elr_state_t                         st;
   elr_pkg::elr_state_t                         next_st;
   elr_pkg::elr_wb_req_t                        req;
   logic [elr_pkg::NUM_SRC-1:0]                 src;
   logic [elr_pkg::NUM_SRC-1:0][elr_pkg::NUM_DEST-1:0] route;
   logic [elr_pkg::NUM_DEST-1:0]                hit;
   logic [elr_pkg::IDX_W-1:0]                   adr_idx;
   logic [elr_pkg::IDX_W-1:0]                   rel_idx;
   logic [elr_pkg::SRC_W-1:0]                   src_idx;
   logic                                        in_sel;
   logic                                        in_seen;
   logic                                        take;
   logic                                        wr_code;
   logic                                        wr_act_lo;
   logic                                        wr_act_hi;
   logic [elr_pkg::DAT_W-1:0]                   rd_word;
   logic [elr_pkg::NUM_DEST-1:0]                act_clr;
   logic [elr_pkg::NUM_DEST-1:0]                act_next;

   ////////////////////////////////////////////////////////////////////////////
   // Source binding

   // Event lines come straight from the peripherals, not from interrupt flags,
   // so masking an interrupt never stops its event from being routed.
   assign src = {
      TARR1_CH2_EVENT_I,       // RULE6
      TARR1_CH1_EVENT_I,       // RULE6
      TARR1_CH0_EVENT_I,       // RULE6
      TARR0_CH7_EVENT_I,       // RULE6
      TARR0_CH6_EVENT_I,       // RULE6
      TARR0_CH5_EVENT_I,       // RULE6
      COMPARATOR0_EVENT_I,     // RULE6
      TARR0_CH4_EVENT_I,       // RULE6
      TARR0_CH3_EVENT_I,       // RULE6
      TARR0_CH2_EVENT_I,       // RULE6
      TARR0_CH1_EVENT_I,       // RULE6
      TARR0_CH0_EVENT_I,       // RULE6
      TMJ0_EVENT_I,            // RULE6
      TMD1_UNDERFLOW_EVENT_I,  // RULE5
      TMD1_MATCH_B_EVENT_I,    // RULE5
      TMD1_MATCH_A_EVENT_I,    // RULE5
      TMD0_MATCH_B_EVENT_I,    // RULE5
      TMD0_MATCH_A_EVENT_I,    // RULE5
      RTC_TICK_EVENT_I,        // RULE4
      KEY_RETURN_EVENT_I,      // RULE4
      EXT_EDGE_EVENT5_I,       // RULE4
      EXT_EDGE_EVENT4_I,       // RULE4
      EXT_EDGE_EVENT3_I,       // RULE4
      EXT_EDGE_EVENT2_I,       // RULE4
      EXT_EDGE_EVENT1_I,       // RULE4
      EXT_EDGE_EVENT0_I        // RULE4 RULE1
   };

   ////////////////////////////////////////////////////////////////////////////
   // Per-source destination decode

   // One decoder per selector keeps each source's route independent of all
   // others; an undefined code decodes to no destination at all.
   for (genvar s = 0; s < elr_pkg::NUM_SRC; s++) begin : g_route // RULE3
      always_comb begin
         route[s] = elr_pkg::DEST_RESET;
         if (src[s]) begin // RULE2
            case (st.dsel[s]) // RULE7 RULE8
               elr_pkg::CODE_ADC:  route[s][elr_pkg::DEST_ADC]  = 1'b1;
               elr_pkg::CODE_TA0:  route[s][elr_pkg::DEST_TA0]  = 1'b1;
               elr_pkg::CODE_TA1:  route[s][elr_pkg::DEST_TA1]  = 1'b1;
               elr_pkg::CODE_TMJ0: route[s][elr_pkg::DEST_TMJ0] = 1'b1;
               elr_pkg::CODE_TMD0: route[s][elr_pkg::DEST_TMD0] = 1'b1;
               elr_pkg::CODE_TMD1: route[s][elr_pkg::DEST_TMD1] = 1'b1;
               elr_pkg::CODE_DAC:  route[s][elr_pkg::DEST_DAC]  = 1'b1;
               elr_pkg::CODE_TA2:  route[s][elr_pkg::DEST_TA2]  = 1'b1;
               elr_pkg::CODE_TA3:  route[s][elr_pkg::DEST_TA3]  = 1'b1;
               elr_pkg::CODE_PWM:  route[s][elr_pkg::DEST_PWM]  = 1'b1;
               default:            route[s] = elr_pkg::DEST_RESET; // RULE18
            endcase
         end
      end
   end

   // Sources sharing one destination in the same cycle merge into one pulse
   always_comb begin
      hit = elr_pkg::DEST_RESET;
      for (int s = 0; s < elr_pkg::NUM_SRC; s++) begin
         hit = hit | route[s]; // RULE18
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register decode

   assign req.cyc = WB_CYC_I;
   assign req.stb = WB_STB_I;
   assign req.we  = WB_WE_I;
   assign req.adr = WB_ADR_I;
   assign req.sel = WB_SEL_I;
   assign req.dat = WB_DAT_I;

   assign adr_idx = req.adr[elr_pkg::ADR_W-1:elr_pkg::ADR_IDX_LSB];
   assign rel_idx = adr_idx - elr_pkg::SEL_BASE_INDEX;
   assign src_idx = rel_idx[elr_pkg::SRC_W-1:0];

   always_comb begin
      in_sel  = 1'b0;
      in_seen = 1'b0;
      if ((adr_idx >= elr_pkg::SEL_BASE_INDEX) && (adr_idx <= elr_pkg::SEL_LAST_INDEX)) begin
         in_sel = 1'b1;
      end else if (adr_idx == elr_pkg::SEEN_INDEX) begin
         in_seen = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus request qualification

   // Only an idle slave takes a request, so a strobe still high during ack
   // is answered as a fresh access two cycles later, never twice at once
   assign take      = req.cyc && req.stb && (st.bus == elr_pkg::ELR_BUS_IDLE);
   assign wr_code   = take && req.we && in_sel && req.sel[elr_pkg::LANE_LO];
   assign wr_act_lo = take && req.we && in_seen && req.sel[elr_pkg::LANE_LO];
   assign wr_act_hi = take && req.we && in_seen && req.sel[elr_pkg::LANE_HI];

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   // Upper selector bits are not stored and read as zero
   always_comb begin
      rd_word = elr_pkg::DAT_ZERO;
      if (in_sel) begin
         rd_word[elr_pkg::CODE_W-1:0] = st.dsel[src_idx];
      end else if (in_seen) begin
         rd_word[elr_pkg::NUM_DEST-1:0] = st.seen;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Activity register

   // Write-one-to-clear per byte lane; a pulse in the clearing cycle still
   // sets its bit, so software never loses an event it has not yet read
   always_comb begin
      act_clr = elr_pkg::DEST_RESET;
      if (wr_act_lo) begin
         act_clr[elr_pkg::ACT_LO_MSB:0] = req.dat[elr_pkg::ACT_LO_MSB:0];
      end
      if (wr_act_hi) begin
         act_clr[elr_pkg::NUM_DEST-1:elr_pkg::ACT_HI_LSB] = req.dat[elr_pkg::NUM_DEST-1:elr_pkg::ACT_HI_LSB];
      end
   end

   assign act_next = (st.seen & ~act_clr) | hit;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_st        = st;
      // Registered paths: one cycle from event to trigger, inside the budget
      next_st.dest_q = hit; // RULE15 RULE16
      next_st.seen   = act_next;
      if (wr_code) begin
         next_st.dsel[src_idx] = req.dat[elr_pkg::CODE_W-1:0]; // RULE3
      end
      case (st.bus)
         elr_pkg::ELR_BUS_IDLE: begin
            if (take) begin
               next_st.bus   = elr_pkg::ELR_BUS_ACK;
               next_st.rdata = rd_word;
            end
         end
         elr_pkg::ELR_BUS_ACK: begin
            // Ack lasts one cycle; idle follows whether or not the strobe has dropped
            next_st.bus = elr_pkg::ELR_BUS_IDLE;
         end
         default: begin
            next_st.bus = elr_pkg::ELR_BUS_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         st.bus    <= elr_pkg::ELR_BUS_IDLE;
         st.dsel   <= {elr_pkg::NUM_SRC{elr_pkg::SEL_RESET}};
         st.dest_q <= elr_pkg::DEST_RESET;
         st.seen   <= elr_pkg::DEST_RESET;
         st.rdata  <= elr_pkg::DAT_ZERO;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign WB_ACK_O = (st.bus == elr_pkg::ELR_BUS_ACK);
   assign WB_DAT_O = st.rdata;

   // ADC and timer-J0 take the event combinationally, no added cycle
   assign ADC_START_O  = hit[elr_pkg::DEST_ADC];  // RULE9 RULE14
   assign TMJ0_COUNT_O = hit[elr_pkg::DEST_TMJ0]; // RULE9 RULE14

   assign DAC_UPDATE_O     = st.dest_q[elr_pkg::DEST_DAC]; // RULE9 RULE15
   assign TARR0_CH0_TRIG_O = st.dest_q[elr_pkg::DEST_TA0]; // RULE10
   assign TARR0_CH1_TRIG_O = st.dest_q[elr_pkg::DEST_TA1]; // RULE10
   assign TARR0_CH2_TRIG_O = st.dest_q[elr_pkg::DEST_TA2]; // RULE10
   assign TARR0_CH3_TRIG_O = st.dest_q[elr_pkg::DEST_TA3]; // RULE10

   // Timer-D capture and cutoff share one pulse; the unit picks its use
   assign TMD0_CAPTURE_O = st.dest_q[elr_pkg::DEST_TMD0]; // RULE11
   assign TMD0_CUTOFF_O  = st.dest_q[elr_pkg::DEST_TMD0]; // RULE11
   assign TMD1_CAPTURE_O = st.dest_q[elr_pkg::DEST_TMD1]; // RULE12
   assign TMD1_CUTOFF_O  = st.dest_q[elr_pkg::DEST_TMD1]; // RULE12

   assign PWM_CUTOFF_O = st.dest_q[elr_pkg::DEST_PWM]; // RULE13 RULE16

endmodule : elr_event_link_router

/* File: logic/elr_pkg.sv */
package elr_pkg;

   localparam int NUM_SRC  = 26;
   localparam int NUM_DEST = 10;
   localparam int CODE_W   = 4;
   localparam int ADR_W    = 24;
   localparam int DAT_W    = 32;
   localparam int IDX_W    = 22;
   localparam int SRC_W    = 5;

   // Printed offsets are register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] SEL_BASE_INDEX = 22'h0F0780;
   localparam logic [IDX_W-1:0] SEL_LAST_INDEX = 22'h0F0799;
   localparam logic [IDX_W-1:0] SEEN_INDEX     = 22'h0F079A;
   localparam int ADR_IDX_LSB = 2;

   // Byte lanes of the activity register
   localparam int LANE_LO    = 0;
   localparam int LANE_HI    = 1;
   localparam int ACT_LO_MSB = 7;
   localparam int ACT_HI_LSB = 8;

   localparam logic [CODE_W-1:0] CODE_OFF  = 4'h0;
   localparam logic [CODE_W-1:0] CODE_ADC  = 4'h1;
   localparam logic [CODE_W-1:0] CODE_TA0  = 4'h2;
   localparam logic [CODE_W-1:0] CODE_TA1  = 4'h3;
   localparam logic [CODE_W-1:0] CODE_TMJ0 = 4'h4;
   localparam logic [CODE_W-1:0] CODE_TMD0 = 4'h5;
   localparam logic [CODE_W-1:0] CODE_TMD1 = 4'h6;
   localparam logic [CODE_W-1:0] CODE_DAC  = 4'h7;
   localparam logic [CODE_W-1:0] CODE_TA2  = 4'h8;
   localparam logic [CODE_W-1:0] CODE_TA3  = 4'h9;
   localparam logic [CODE_W-1:0] CODE_PWM  = 4'hA;

   // Destination bit positions, one per defined code
   localparam int DEST_ADC  = 0;
   localparam int DEST_TA0  = 1;
   localparam int DEST_TA1  = 2;
   localparam int DEST_TMJ0 = 3;
   localparam int DEST_TMD0 = 4;
   localparam int DEST_TMD1 = 5;
   localparam int DEST_DAC  = 6;
   localparam int DEST_TA2  = 7;
   localparam int DEST_TA3  = 8;
   localparam int DEST_PWM  = 9;

   localparam logic [CODE_W-1:0]   SEL_RESET  = 4'h0;
   localparam logic [NUM_DEST-1:0] DEST_RESET = 10'h000;
   localparam logic [DAT_W-1:0]    DAT_ZERO   = 32'h0000_0000;

   typedef enum logic [1:0] {
      ELR_BUS_IDLE = 2'b01,
      ELR_BUS_ACK  = 2'b10
   } elr_bus_t;

   typedef struct packed {
      logic                  cyc;
      logic                  stb;
      logic                  we;
      logic [ADR_W-1:0]      adr;
      logic [3:0]            sel;
      logic [DAT_W-1:0]      dat;
   } elr_wb_req_t;

   typedef struct packed {
      elr_bus_t                          bus;
      logic [NUM_SRC-1:0][CODE_W-1:0]    dsel;
      logic [NUM_DEST-1:0]               dest_q;
      logic [NUM_DEST-1:0]               seen;
      logic [DAT_W-1:0]                  rdata;
   } elr_state_t;

endpackage : elr_pkg

/* File: sim/elr_event_link_router_asserts.sv */
`timescale 1ns/1ns
module elr_event_link_router_asserts (
   input wire logic        CORE_CLK_I,
   input wire logic        RESET_N_I,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic        TMD0_CAPTURE_O,
   input wire logic        TMD0_CUTOFF_O,
   input wire logic        TMD1_CAPTURE_O,
   input wire logic        TMD1_CUTOFF_O,
   input wire logic        DAC_UPDATE_O,
   input wire logic        PWM_CUTOFF_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   ////////////////////////////////////////////////////////////
   chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack stood longer than one cycle");
   chk_ack_answer: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
      else $error("request not answered on the next cycle");
   chk_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without a request");
   chk_read_hold: assert property (!WB_ACK_O |-> $stable(WB_DAT_O))
      else $error("read data moved between accesses");
   chk_code_width: assert property (WB_ACK_O |-> WB_DAT_O[31:10] == 22'h000000)
      else $error("read data has bits above the fields");
   chk_unit0_pair: assert property (TMD0_CAPTURE_O == TMD0_CUTOFF_O)
      else $error("unit0 capture and cutoff differ");
   chk_unit1_pair: assert property (TMD1_CAPTURE_O == TMD1_CUTOFF_O)
      else $error("unit1 capture and cutoff differ");
   chk_reset_quiet: assert property ($rose(RESET_N_I) |->
      !(DAC_UPDATE_O || PWM_CUTOFF_O || TMD0_CAPTURE_O || TMD1_CAPTURE_O))
      else $error("trigger right after reset");
   cover property (WB_ACK_O);
   cover property (DAC_UPDATE_O);
   cover property (PWM_CUTOFF_O);
endmodule : elr_event_link_router_asserts

bind elr_event_link_router elr_event_link_router_asserts chk_u (
   .CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TMD0_CAPTURE_O(TMD0_CAPTURE_O),
   .TMD0_CUTOFF_O(TMD0_CUTOFF_O), .TMD1_CAPTURE_O(TMD1_CAPTURE_O), .TMD1_CUTOFF_O(TMD1_CUTOFF_O),
   .DAC_UPDATE_O(DAC_UPDATE_O), .PWM_CUTOFF_O(PWM_CUTOFF_O)
);

/* File: sim/elr_event_link_router_test.sv */
`timescale 1ns/1ns
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
   $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module elr_event_link_router_test;
   logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0;
   logic        ack, adc, dac, tmj, pwm, c0, k0, c1, k1;
   logic [23:0] adr = 24'h000000;
   logic [3:0]  sel = 4'h0;
   logic [3:0]  ta;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat, e, d;
   logic [25:0] ev;
   logic [4:0]  idx = 5'h00;
   logic [1:0]  comb_q = 2'b00;
   logic [9:0]  obs;
   logic [9:0]  act = 10'h000;
   logic [31:0] rd_q[$];
   logic [9:0]  ev_q[$];
   logic [3:0]  codes[26];
   int          mismatches = 0;
   int          total_checks = 0;
   int          s;
   localparam logic [21:0] BASE = elr_pkg::SEL_BASE_INDEX;
   ////////////////////////////////////////////////////////////
   elr_src_model src_u (.fire_i(fire), .idx_i(idx), .ev_o(ev));
   elr_event_link_router dut_u (
      .CORE_CLK_I(clk), .RESET_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .EXT_EDGE_EVENT0_I(ev[0]), .EXT_EDGE_EVENT1_I(ev[1]), .EXT_EDGE_EVENT2_I(ev[2]),
      .EXT_EDGE_EVENT3_I(ev[3]), .EXT_EDGE_EVENT4_I(ev[4]), .EXT_EDGE_EVENT5_I(ev[5]),
      .KEY_RETURN_EVENT_I(ev[6]), .RTC_TICK_EVENT_I(ev[7]), .TMD0_MATCH_A_EVENT_I(ev[8]),
      .TMD0_MATCH_B_EVENT_I(ev[9]), .TMD1_MATCH_A_EVENT_I(ev[10]), .TMD1_MATCH_B_EVENT_I(ev[11]),
      .TMD1_UNDERFLOW_EVENT_I(ev[12]), .TMJ0_EVENT_I(ev[13]), .TARR0_CH0_EVENT_I(ev[14]),
      .TARR0_CH1_EVENT_I(ev[15]), .TARR0_CH2_EVENT_I(ev[16]), .TARR0_CH3_EVENT_I(ev[17]),
      .TARR0_CH4_EVENT_I(ev[18]), .COMPARATOR0_EVENT_I(ev[19]), .TARR0_CH5_EVENT_I(ev[20]),
      .TARR0_CH6_EVENT_I(ev[21]), .TARR0_CH7_EVENT_I(ev[22]), .TARR1_CH0_EVENT_I(ev[23]),
      .TARR1_CH1_EVENT_I(ev[24]), .TARR1_CH2_EVENT_I(ev[25]), .ADC_START_O(adc),
      .DAC_UPDATE_O(dac), .TARR0_CH0_TRIG_O(ta[0]), .TARR0_CH1_TRIG_O(ta[1]),
      .TARR0_CH2_TRIG_O(ta[2]), .TARR0_CH3_TRIG_O(ta[3]), .TMJ0_COUNT_O(tmj),
      .TMD0_CAPTURE_O(c0), .TMD0_CUTOFF_O(k0), .TMD1_CAPTURE_O(c1), .TMD1_CUTOFF_O(k1),
      .PWM_CUTOFF_O(pwm)
   );
   initial begin
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////
   // Same-cycle outputs are delayed one edge so every destination is judged together
   assign obs = {pwm, ta[3], ta[2], dac, c1, c0, comb_q[1], ta[1], ta[0], comb_q[0]};
   always @(posedge clk) begin
      comb_q <= {tmj, adc};
      if (ack && cyc && !we) begin
         e = rd_q.size() ? rd_q.pop_front() : 32'hFFFF_FFFF;
         `CHK("read data", e, rdat)
      end
      if (rst_n && obs !== 10'h000) begin
         e = ev_q.size() ? {22'h000000, ev_q.pop_front()} : 32'h0000_03FF;
         `CHK("destination", e[9:0], obs)
      end
      `CHK("capture vs cutoff", {c0, c1}, {k0, k1})
   end
   ////////////////////////////////////////////////////////////
   task automatic wb(input logic w, input logic [21:0] i, input logic [31:0] dt);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {i, 2'b00};
      sel  <= 4'hF;
      wdat <= dt;
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic rd(input logic [21:0] i, input logic [31:0] x);
      rd_q.push_back(x);
      wb(1'b0, i, 32'h0000_0000);
   endtask : rd
   // Leaves the source firing; the caller ends the burst
   task automatic pulse(input int n, input logic [3:0] k);
      if (k != 4'h0 && k <= 4'hA) begin
         ev_q.push_back(10'h001 << (k - 4'h1));
         act = act | (10'h001 << (k - 4'h1));
      end
      fire <= 1'b1;
      idx  <= n[4:0];
      @(posedge clk);
      `CHK("same-cycle trigger", {tmj, adc}, {k == 4'h4, k == 4'h1})
   endtask : pulse
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #200000;
      mismatches++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(12901));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 26; i++) rd(BASE + 22'(i), 32'h0);
      wb(1'b1, BASE - 22'h1, 32'h0000_0005);
      rd(BASE - 22'h1, 32'h0);
      for (int k = 0; k <= 10; k++) begin
         s = $urandom_range(25);
         d = $urandom();
         d[3:0] = 4'(k);
         wb(1'b1, BASE + 22'(s), d);
         rd(BASE + 22'(s), {28'h0, d[3:0]});
         pulse(s, d[3:0]);
         fire <= 1'b0;
         @(posedge clk);
      end
      for (int n = 0; n < 26; n++) begin
         codes[n] = 4'($urandom_range(10, 1));
         wb(1'b1, BASE + 22'(n), {28'h0, codes[n]});
      end
      for (int n = 0; n < 26; n++) pulse(n, codes[n]);
      pulse(25, codes[25]);
      fire <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK("pending events", 0, ev_q.size())
      rd(elr_pkg::SEEN_INDEX, {22'h000000, act});
      wb(1'b1, elr_pkg::SEEN_INDEX, 32'h0000_03FF);
      rd(elr_pkg::SEEN_INDEX, 32'h0);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(BASE + 22'h19, 32'h0);
      pulse(25, 4'h0);
      fire <= 1'b0;
      repeat (4) @(posedge clk);
      end_of_test();
   end
endmodule : elr_event_link_router_test

/* File: sim/elr_src_model.sv */
`timescale 1ns/1ns
module elr_src_model (
   input  wire logic        fire_i,
   input  wire logic [4:0]  idx_i,
   output logic      [25:0] ev_o
);
   // One source a cycle, so each pulse can be traced to a single selector
   assign ev_o = fire_i ? (26'h0000001 << idx_i) : 26'h0000000;
endmodule : elr_src_model
